// ---- dv/arf_analog_model.sv ----
// Behavioural model of the analogue input pins and the temperature sensor.
`timescale 1ns/1ps
module arf_analog_model #(
  parameter logic [9:0] BANDGAP_LEVEL = 10'h180,  // Plain default bandgap level.
  parameter logic [9:0] SENSOR_LEVEL  = 10'h12C   // Plain default sensor reading.
) (
  input  wire logic        clk_in,
  input  wire logic        busy_in,
  input  wire logic [3:0]  channel_gain_select_in,
  input  wire logic [39:0] pin_levels_in,
  output logic      [9:0]  pos_level_out,
  output logic      [9:0]  neg_level_out
);
  logic [9:0] pin_reg [4];  // Pin levels, one per input.
  // Quiet pins: levels only move between conversions.
  always_ff @(posedge clk_in) begin
    for (int i = 0; i < 4; i++) if (!busy_in) pin_reg[i] <= pin_levels_in[i*10 +: 10];
  end
  // Routing by channel code; the unassigned code gives a pattern, not a level.
  always_comb begin
    neg_level_out = 10'h000;
    case (channel_gain_select_in)
      4'h0, 4'h1, 4'h2, 4'h3: pos_level_out = pin_reg[channel_gain_select_in[1:0]];
      4'h4, 4'h5: begin pos_level_out = pin_reg[2]; neg_level_out = pin_reg[2]; end
      4'h6, 4'h7: begin pos_level_out = pin_reg[2]; neg_level_out = pin_reg[3]; end
      4'h8, 4'h9: begin pos_level_out = pin_reg[0]; neg_level_out = pin_reg[0]; end
      4'hA, 4'hB: begin pos_level_out = pin_reg[0]; neg_level_out = pin_reg[1]; end
      4'hC: pos_level_out = BANDGAP_LEVEL;
      4'hD: pos_level_out = 10'h000;
      4'hF: pos_level_out = SENSOR_LEVEL;
      default: pos_level_out = 10'h2AA;
    endcase
  end
endmodule : arf_analog_model

// ---- dv/arf_sva.sv ----
// Port-level checker for the converter control block, bound to its top module.
`timescale 1ns/1ps
module arf_checker
  import arf_pkg::*;
(
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  input wire logic [7:0]  addr_in,
  input wire logic [7:0]  wdata_in,
  input wire logic        wr_in,
  input wire logic        rd_in,
  input wire logic [7:0]  rdata_out,
  input wire logic        conv_clk_en_in,
  input wire logic        start_in,
  input wire logic [3:0]  channel_gain_select_out,
  input wire logic [2:0]  reference_select_out,
  input arf_ref_type      ref_source_out,
  input wire logic        sensor_enable_out,
  input wire logic        gain_twenty_out,
  input wire logic        busy_out,
  input wire logic        irq_out
);
  // ==========================================================================
  // Helper logic.
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  wire logic [2:0] sel_w = reference_select_out;  // Short alias of the field.
  arf_ref_type     exp_ref;                       // Source expected from the field.
  logic [5:0]      pulse_cnt_reg;                 // Converter pulses seen while busy.
  assign exp_ref = (sel_w[1:0] == 2'b00) ? ARF_REF_SUPPLY :
                   (sel_w[1:0] == 2'b01) ? ARF_REF_EXTERNAL :
                   (sel_w == 3'b010) ? ARF_REF_INT_1V1 :
                   (sel_w == 3'b011) ? ARF_REF_RESERVED :
                   (sel_w == 3'b110) ? ARF_REF_INT_2V56 : ARF_REF_INT_2V56_BYPASS;
  // The count clears whenever idle, so it holds one conversion's length.
  always_ff @(posedge clk_in) begin
    pulse_cnt_reg <= (rst_n_in && busy_out) ? pulse_cnt_reg + 6'(conv_clk_en_in) : 6'h00;
  end
  sequence s_start_taken;
    !busy_out && start_in;
  endsequence
  // ==========================================================================
  // Assertions.
  a_busy_start: assert property (s_start_taken |=> busy_out)
    else $error("start while idle did not raise busy");
  a_conv_length: assert property ($fell(busy_out) |-> pulse_cnt_reg inside {6'd13, 6'd25})
    else $error("conversion length is neither 13 nor 25 pulses");
  a_select_locked: assert property ($rose(busy_out) |-> ##1
    $stable({channel_gain_select_out, reference_select_out})[*8])
    else $error("selection changed during a conversion");
  a_sensor_enable: assert property (sensor_enable_out == (channel_gain_select_out == 4'hF))
    else $error("sensor enable does not follow code 1111");
  a_gain_twenty: assert property (gain_twenty_out ==
    (channel_gain_select_out inside {[4'h4:4'hB]} && channel_gain_select_out[0]))
    else $error("gain selection wrong for channel code");
  a_ref_decode: assert property (ref_source_out == exp_ref)
    else $error("reference source decode wrong");
  a_read_quiet: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
    else $error("read data present without a read");
  a_irq_cause: assert property ($rose(irq_out) |-> $past(busy_out) || $past(wr_in))
    else $error("interrupt rose without completion or write");
  a_irq_clear: assert property (wr_in && addr_in == 8'h06 && wdata_in[0] && !busy_out
    |=> !irq_out)
    else $error("interrupt stayed after done flag clear");
endmodule : arf_checker

bind arf_converter_ctrl arf_checker u_arf_checker (.clk_in(clk_in), .rst_n_in(rst_n_in),
  .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
  .conv_clk_en_in(conv_clk_en_in), .start_in(start_in), .busy_out(busy_out), .irq_out(irq_out),
  .channel_gain_select_out(channel_gain_select_out), .ref_source_out(ref_source_out),
  .reference_select_out(reference_select_out), .sensor_enable_out(sensor_enable_out),
  .gain_twenty_out(gain_twenty_out));

// ---- dv/test_arf_converter_ctrl.sv ----
// Self-checking bench for the converter control block.
`timescale 1ns/1ps
module test_arf_converter_ctrl;
  import arf_pkg::*;
  logic clk_in = 0, rst_n_in = 0, wr_in = 0, rd_in = 0, start_in = 0, conv_clk_en_in = 0;
  logic [7:0] addr_in = 0, wdata_in = 0, rdata_out, rd_val;
  logic [3:0] cgs;
  logic [2:0] rsel;
  arf_ref_type rsrc;
  logic sens, g20, busy_out, irq_out;
  logic [9:0] pos_w, neg_w;
  logic [39:0] pins = 0;
  int fail_count = 0, checks_done = 0, cyc = 0, en_seen = 0;
  // ==========================================================================
  // Clock, converter pulses every fourth cycle, pulse tally and hang guard.
  always #12.5 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cyc++;
    conv_clk_en_in <= (cyc % 4 == 0);
    if (busy_out && conv_clk_en_in) en_seen++;
    if (cyc > 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  arf_converter_ctrl u_arf_converter_ctrl (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .conv_clk_en_in(conv_clk_en_in), .start_in(start_in), .pos_level_in(pos_w),
    .neg_level_in(neg_w), .channel_gain_select_out(cgs), .reference_select_out(rsel),
    .ref_source_out(rsrc), .sensor_enable_out(sens), .gain_twenty_out(g20),
    .busy_out(busy_out), .irq_out(irq_out));
  arf_analog_model u_arf_analog_model (.clk_in(clk_in), .busy_in(busy_out),
    .channel_gain_select_in(cgs), .pin_levels_in(pins), .pos_level_out(pos_w),
    .neg_level_out(neg_w));
  // ==========================================================================
  // Bus cycles, comparison, expected result and closing report.
  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (exp !== got) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a; wdata_in <= d; wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
    #1;
  endtask : wr
  task rd(input logic [7:0] a);
    @(posedge clk_in);
    addr_in <= a; rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 rd_val = rdata_out;
  endtask : rd
  // Swap, gain, clamp and signed halving, worked out from the mode bits.
  function logic [9:0] want(logic [3:0] c, logic b, logic s, logic [9:0] p, logic [9:0] n);
    logic [9:0] t;
    logic [15:0] d;
    if (!(c inside {[4'h4:4'hB]})) return p;
    if (s) begin t = p; p = n; n = t; end
    d = (p > n) ? 16'(p - n) : 16'(n - p);
    if (c[0]) d = d * 16'd20;
    if (d > 16'h03FF) d = 16'h03FF;
    if (!b) return (n > p) ? 10'h000 : d[9:0];
    return (n > p) ? ~d[10:1] + 10'h001 : d[10:1];
  endfunction : want
  task tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish
  // ==========================================================================
  // Main sequence: reset values, then random conversions with corner cases.
  initial begin
    logic [7:0] isel;
    logic [3:0] code;
    logic [2:0] rs, last_rs;
    logic b, s, m, chg;
    logic [9:0] er;
    int exp_len;
    last_rs = 3'h0; chg = 1'b0;
    void'($urandom(32'h8f21));
    repeat (5) @(posedge clk_in);
    rst_n_in <= 1'b1;
    rd(8'h07); chk("input select reset", 8'h00, rd_val);
    rd(8'h08); chk("control b reset", 8'h00, rd_val);
    rd(8'hFF); chk("unmapped read", 8'h00, rd_val);
    for (int i = 0; i < 24; i++) begin
      code = 4'($urandom);
      if (code == 4'hE) code = 4'hF;
      {b, s, m} = 3'($urandom);
      rs = (code == 4'hF) ? 3'b010 : 3'($urandom);
      pins <= 40'({$urandom, $urandom}) & ((b && code[0]) ? {4{10'h01F}} : {40{1'b1}});
      isel = {rs[1:0], 1'b0, rs[2], code};
      if (rs != last_rs) chg = 1'b1;
      last_rs = rs;
      wr(8'h08, {b, 1'b0, s, 5'h00});
      wr(8'h09, {7'h00, m});
      wr(8'h07, isel);
      chk("channel", code, cgs);
      chk("reference", rs, rsel);
      rd(8'h07); chk("input select", isel, rd_val);
      en_seen = 0;
      @(posedge clk_in);
      start_in <= 1'b1;
      @(posedge clk_in);
      start_in <= 1'b0;
      #1 er = want(code, b, s, pos_w, neg_w);
      chk("busy", 1'b1, busy_out);
      exp_len = chg ? 25 : 13;
      chg = 1'b0;
      if (i % 3 == 0) begin
        isel = isel ^ 8'h40;
        last_rs = {isel[4], isel[7:6]};
        chg = 1'b1;
        wr(8'h07, isel);
        chk("reference held", rs, rsel);
      end
      for (int k = 0; k < 400 && busy_out !== 1'b0; k++) @(posedge clk_in);
      #1 chk("pulse count", 16'(exp_len), 16'(en_seen));
      chk("interrupt", m, irq_out);
      for (int j = 0; j < 2; j++) begin
        wr(8'h07, {isel[7:6], j[0], isel[4:0]});
        rd(8'h05); chk("result", j ? er[9:2] : 8'(er[9:8]), rd_val);
        rd(8'h04); chk("result low", j ? {er[1:0], 6'h00} : er[7:0], rd_val);
      end
      wr(8'h06, 8'h01);
      chk("interrupt clear", 1'b0, irq_out);
      $display("conversion %0d code %h finished", i, code);
    end
    tally_and_finish();
  end
endmodule : test_arf_converter_ctrl

// ---- src/arf_code_format.sv ----
// Combinational formatter from raw converter code to a ten-bit result.
`timescale 1ns/1ps
`include "arf_regs.svh"
module arf_code_format
  import arf_pkg::*;
(
  input  wire logic        diff_in,       // Differential channel in use.
  input  wire logic        bipolar_in,    // Bipolar mode requested.
  input  wire logic        negative_in,   // Positive input below negative.
  input  wire logic [9:0]  magnitude_in,  // Gained magnitude of the input.
  output logic      [9:0]  code_out       // Formatted ten-bit code.
);
  // Bipolar uses half scale: the magnitude, already saturated at full scale, is halved.
  logic [8:0] half_mag;
  logic [9:0] signed_code;
  logic       use_bipolar;
  assign use_bipolar = diff_in & bipolar_in;
  assign half_mag = magnitude_in[9:1];
  // Negation of up to 511 stays inside the lower limit; the sign lands in bit nine.
  assign signed_code = negative_in ? (~{1'b0, half_mag} + 10'h001) : {1'b0, half_mag};
  // Unipolar differential clamps a negative difference to zero.
  assign code_out = use_bipolar ? signed_code :
                    (diff_in & negative_in) ? `ARF_ZERO_CODE : magnitude_in;
endmodule : arf_code_format

// ---- src/arf_converter_ctrl.sv ----
// Converter control: input select, reference latch, result formatting and registers.
`timescale 1ns/1ps
`include "arf_regs.svh"
module arf_converter_ctrl
  import arf_pkg::*;
(
  input  wire logic        clk_in,              // System clock, 40 MHz.
  input  wire logic        rst_n_in,            // Synchronous reset, active low.
  input  wire logic [7:0]  addr_in,             // Register address.
  input  wire logic [7:0]  wdata_in,            // Write data.
  input  wire logic        wr_in,               // Write strobe.
  input  wire logic        rd_in,               // Read strobe.
  output logic      [7:0]  rdata_out,           // Read data, cycle after strobe.
  input  wire logic        conv_clk_en_in,      // Converter clock enable pulse.
  input  wire logic        start_in,            // Start one conversion.
  input  wire logic [9:0]  pos_level_in,        // Sampled positive input level.
  input  wire logic [9:0]  neg_level_in,        // Sampled negative input level.
  output logic      [3:0]  channel_gain_select_out, // Channel code in use.
  output logic      [2:0]  reference_select_out,    // Reference field in use.
  output arf_ref_type      ref_source_out,      // Decoded reference source.
  output logic             sensor_enable_out,   // Temperature sensor enabled.
  output logic             gain_twenty_out,     // Twenty times gain selected.
  output logic             busy_out,            // Conversion running.
  output logic             irq_out              // Level interrupt.
);
  // ==========================================================================
  // Register state.
  logic [7:0]  input_select_reg;     // Software copy of the input select register.
  logic [7:0]  control_b_reg;        // Bipolar and swap bits.
  logic [7:0]  irq_mask_reg;         // Interrupt mask.
  logic        done_reg;             // Sticky conversion done flag.
  logic [9:0]  result_reg;           // Latest right-justified result.
  logic [3:0]  chan_lock_reg;        // Channel code held during conversion.
  logic [2:0]  ref_lock_reg;         // Reference held during conversion.
  logic        ref_changed_reg;      // Reference changed since last start.
  logic [4:0]  cycle_reg;            // Converter cycles remaining.
  logic [7:0]  rdata_reg;            // Registered read data.
  arf_state_type state_reg;          // Sequencer state.

  // ==========================================================================
  // Decode of the bus and of the fields.
  wire [2:0] ref_field = {input_select_reg[`ARF_IS_REF_TOP_BIT], input_select_reg[7:6]};
  wire       wr_is   = wr_in & (addr_in == `ARF_INPUT_SELECT_OFS);
  wire       wr_cb   = wr_in & (addr_in == `ARF_CONTROL_B_OFS);
  wire       wr_mask = wr_in & (addr_in == `ARF_IRQ_MASK_OFS);
  wire       wr_st   = wr_in & (addr_in == `ARF_STATUS_OFS);
  wire       idle    = (state_reg == ARF_IDLE);
  // Channel codes four through eleven are differential pairs.
  // Decoded from the code in use, so it follows software while idle and stays locked while busy.
  wire       diff_sel = (channel_gain_select_out[3:2] == 2'b01) |
                        (channel_gain_select_out[3:2] == 2'b10);
  wire       finish  = (state_reg == ARF_CONVERT) & conv_clk_en_in & (cycle_reg == 5'd1);
  wire [2:0] ref_next = {wdata_in[`ARF_IS_REF_TOP_BIT], wdata_in[7:6]};
  wire       ref_write_chg = wr_is & (ref_next != ref_field);

  // Selections follow software while idle, locked while converting.
  assign channel_gain_select_out = idle ? input_select_reg[3:0] : chan_lock_reg;
  assign reference_select_out    = idle ? ref_field : ref_lock_reg;
  assign sensor_enable_out = (channel_gain_select_out == `ARF_SENSOR_CODE);
  assign gain_twenty_out   = diff_sel & channel_gain_select_out[0];
  assign busy_out = ~idle;

  // Reference decode; the top bit only matters when bit 1 is set.
  always_comb begin
    unique case ({reference_select_out[1:0]})
      2'b00: ref_source_out = ARF_REF_SUPPLY;
      2'b01: ref_source_out = ARF_REF_EXTERNAL;
      2'b10: ref_source_out = reference_select_out[2] ? ARF_REF_INT_2V56 : ARF_REF_INT_1V1;
      2'b11: ref_source_out = reference_select_out[2] ? ARF_REF_INT_2V56_BYPASS
                                                      : ARF_REF_RESERVED;
    endcase
  end

  // ==========================================================================
  // Differential path: swap, difference and gain.
  wire        swap    = control_b_reg[`ARF_CB_SWAP_BIT];
  wire [9:0]  pos_eff = (diff_sel & swap) ? neg_level_in : pos_level_in;
  wire [9:0]  neg_eff = (diff_sel & swap) ? pos_level_in : neg_level_in;
  wire        negative = neg_eff > pos_eff;
  wire [9:0]  diff_mag = negative ? (neg_eff - pos_eff) : (pos_eff - neg_eff);
  // Twenty times gain saturates at full scale rather than wrap.
  wire [14:0] gained = {5'h00, diff_mag} * 15'd20;
  wire [9:0]  mag = ~diff_sel ? pos_level_in :
                    ~gain_twenty_out ? diff_mag :
                    (gained > 15'h03FF) ? `ARF_FULL_CODE : gained[9:0];
  logic [9:0] formatted;

  arf_code_format u_format (
    .diff_in      (diff_sel),
    .bipolar_in   (control_b_reg[`ARF_CB_BIPOLAR_BIT]),
    .negative_in  (negative),
    .magnitude_in (mag),
    .code_out     (formatted)
  );

  // ==========================================================================
  // Presentation: left justify acts on stored result at once.
  wire        left = input_select_reg[`ARF_IS_LEFT_BIT];
  wire [15:0] shown = left ? {result_reg, 6'h00} : {6'h00, result_reg};
  wire [7:0]  status = {6'h00, ~idle, done_reg};
  logic [7:0] rdata_next_c;        // Read data chosen by the address.
  always_comb begin
    unique case (addr_in)
      `ARF_RESULT_LOW_OFS:   rdata_next_c = shown[7:0];
      `ARF_RESULT_HIGH_OFS:  rdata_next_c = shown[15:8];
      `ARF_STATUS_OFS:       rdata_next_c = status;
      `ARF_INPUT_SELECT_OFS: rdata_next_c = input_select_reg;
      `ARF_CONTROL_B_OFS:    rdata_next_c = control_b_reg;
      `ARF_IRQ_MASK_OFS:     rdata_next_c = irq_mask_reg;
      default:               rdata_next_c = `ARF_REG_RESET;
    endcase
  end
  assign rdata_out = rdata_reg;
  assign irq_out = done_reg & irq_mask_reg[`ARF_ST_DONE_BIT];

  // ==========================================================================
  // Registers written by software.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      input_select_reg <= `ARF_REG_RESET;
      control_b_reg    <= `ARF_REG_RESET;
      irq_mask_reg     <= `ARF_REG_RESET;
      rdata_reg        <= `ARF_REG_RESET;
    end else begin
      if (wr_is) input_select_reg <= wdata_in;
      if (wr_cb) control_b_reg <= wdata_in;
      if (wr_mask) irq_mask_reg <= wdata_in;
      rdata_reg <= rd_in ? rdata_next_c : `ARF_REG_RESET;
    end
  end

  // Sequencer: lock selections at start, length from reference change.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_reg       <= ARF_IDLE;
      cycle_reg       <= 5'd0;
      chan_lock_reg   <= 4'h0;
      ref_lock_reg    <= 3'h0;
      ref_changed_reg <= 1'b0;
      result_reg      <= `ARF_ZERO_CODE;
      done_reg        <= 1'b0;
    end else begin
      // A change of the reference field marks the next conversion long.
      if (ref_write_chg) begin
        ref_changed_reg <= 1'b1;
      end
      unique case (state_reg)
        ARF_IDLE: begin
          if (start_in) begin
            state_reg     <= ARF_CONVERT;
            chan_lock_reg <= input_select_reg[3:0];
            ref_lock_reg  <= ref_field;
            cycle_reg     <= ref_changed_reg ? `ARF_LONG_CYCLES : `ARF_NORMAL_CYCLES;
            // A reference write in the start cycle still marks the next conversion long.
            ref_changed_reg <= ref_write_chg;
          end
        end
        ARF_CONVERT: begin
          if (conv_clk_en_in) cycle_reg <= cycle_reg - 5'd1;
          if (finish) begin
            result_reg <= formatted;
            state_reg  <= ARF_FINISH;
          end
        end
        ARF_FINISH: state_reg <= ARF_IDLE;
      endcase
      // Set wins over a simultaneous write-one clear.
      if (finish) done_reg <= 1'b1;
      else if (wr_st && wdata_in[`ARF_ST_DONE_BIT]) done_reg <= 1'b0;
    end
  end
endmodule : arf_converter_ctrl

// ---- src/arf_pkg.sv ----
// Types shared by the result formatter files.
package arf_pkg;
  // Reference source decoded from the reference field.
  typedef enum logic [2:0] {
    ARF_REF_SUPPLY, ARF_REF_EXTERNAL, ARF_REF_INT_1V1, ARF_REF_RESERVED,
    ARF_REF_INT_2V56, ARF_REF_INT_2V56_BYPASS
  } arf_ref_type;
  // Sequencer states.
  typedef enum logic [1:0] {ARF_IDLE, ARF_CONVERT, ARF_FINISH} arf_state_type;
endpackage : arf_pkg

// ---- src/arf_regs.svh ----
// Register offsets, field positions, reset values and timing counts of the result formatter.
// ============================================================================
`ifndef ARF_REGS_SVH
`define ARF_REGS_SVH

// ============================================================================
// Register offsets.
`define ARF_RESULT_LOW_OFS    8'h04
`define ARF_RESULT_HIGH_OFS   8'h05
`define ARF_STATUS_OFS        8'h06
`define ARF_INPUT_SELECT_OFS  8'h07
`define ARF_CONTROL_B_OFS     8'h08
`define ARF_IRQ_MASK_OFS      8'h09

// ============================================================================
// Field positions.
`define ARF_IS_LEFT_BIT       5
`define ARF_IS_REF_TOP_BIT    4
`define ARF_CB_BIPOLAR_BIT    7
`define ARF_CB_SWAP_BIT       5
`define ARF_ST_DONE_BIT       0
`define ARF_ST_BUSY_BIT       1

// ============================================================================
// Reset values and codes.
`define ARF_REG_RESET         8'h00
`define ARF_SENSOR_CODE       4'hF
`define ARF_ZERO_CODE         10'h000
`define ARF_FULL_CODE         10'h3FF
`define ARF_NEG_LIMIT         10'h200
`define ARF_POS_LIMIT         10'h1FF

// ============================================================================
// Conversion lengths in converter clock cycles.
`define ARF_NORMAL_CYCLES     5'd13
`define ARF_LONG_CYCLES       5'd25

`endif
